// [src/fbdr_pkg.sv]
// Function
// [R1] Five data bits, each with differential input and complementary output, one shared clock
// [R2] Bits capture data only on rising edge of true clock; hold otherwise
// [R3] Clear high forces all stored bits to zero at once, no clock needed
// [R4] Open input pair reads as complement asserted: data zero, clock low
// [R5] Unused bits may be left open without disturbing other bits
// [R6] Clock and data both open: output settles valid, value undefined
// [R7] Clock edges ignored while clear high; change only on later edge
package fbdr_pkg;
	localparam int WIDTH = 5;
	localparam logic [WIDTH-1:0] CLEAR_VAL = 5'h00;
	// Clock history after reset or clear reads high, so only a fresh rise captures
	localparam logic CLK_HIST_INIT = 1'b1;

	// One differential input pair; open pair is signalled by its own flag
	typedef struct packed {
		logic truePin;
		logic compPin;
		logic isOpen;
	} fbdr_diff_t;

	typedef struct packed {
		logic [WIDTH-1:0] trueOut;
		logic [WIDTH-1:0] compOut;
	} fbdr_out_t;
endpackage

// [src/fbdr_diff_rx.sv]
module fbdr_diff_rx (
	// Pair in
	input wire fbdr_pkg::fbdr_diff_t pairIn,
	// Resolved level
	output logic level
);
	// Clamp drives the complement side, so an open pair resolves low
	always_comb begin
		if (pairIn.isOpen) begin
			level = 1'b0; // [R4]
		end else begin
			level = pairIn.truePin & ~pairIn.compPin;
		end
	end
endmodule // fbdr_diff_rx

// [src/fbdr_register.sv]
module fbdr_register (
	// Clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// Clear, active high
	input wire logic async_clear,
	// Differential clock and data
	input wire fbdr_pkg::fbdr_diff_t clkPair,
	input wire fbdr_pkg::fbdr_diff_t [fbdr_pkg::WIDTH-1:0] dataPair,
	// Complementary outputs
	output fbdr_pkg::fbdr_out_t dataOut
);
	// Output word kept in its own flops so the pins see no gate after the register
	typedef struct packed {
		logic linkClk;
		logic [fbdr_pkg::WIDTH-1:0] store;
		fbdr_pkg::fbdr_out_t outWord;
	} fbdr_state_t;

	fbdr_state_t state_q;
	fbdr_state_t state_d;
	logic clkLevel;
	logic [fbdr_pkg::WIDTH-1:0] dataLevel;
	logic clkRise;

	fbdr_diff_rx uClkRx (
		.pairIn(clkPair),
		.level(clkLevel)
	);

	// Each bit resolves alone, so open pairs on one bit touch no other
	for (genvar i = 0; i < fbdr_pkg::WIDTH; i++) begin : gRx
		fbdr_diff_rx uDataRx (
			.pairIn(dataPair[i]),
			.level(dataLevel[i])
		); // [R5]
	end

	// Open clock stays low, so no edge appears and the stored value is kept
	assign clkRise = clkLevel & ~state_q.linkClk; // [R6]

	// Next state: clear outranks a clock edge, and the outputs follow the store
	always_comb begin
		state_d = state_q;
		state_d.linkClk = clkLevel;
		if (async_clear) begin
			// History reads high, so a clock already high at release is no edge
			state_d.linkClk = fbdr_pkg::CLK_HIST_INIT; // [R7]
			state_d.store = fbdr_pkg::CLEAR_VAL; // [R7]
		end else if (clkRise) begin
			state_d.store = dataLevel; // [R2]
		end
		state_d.outWord.trueOut = state_d.store; // [R1]
		state_d.outWord.compOut = ~state_d.store; // [R1]
	end

	// Clear is a second asynchronous control; like the reset it only loads constants
	always_ff @(posedge core_clk or negedge arst_n or posedge async_clear) begin
		if (!arst_n) begin
			state_q.linkClk <= fbdr_pkg::CLK_HIST_INIT;
			state_q.store <= fbdr_pkg::CLEAR_VAL;
			state_q.outWord.trueOut <= fbdr_pkg::CLEAR_VAL;
			state_q.outWord.compOut <= ~fbdr_pkg::CLEAR_VAL;
		end else if (async_clear) begin
			state_q.linkClk <= fbdr_pkg::CLK_HIST_INIT; // [R7]
			state_q.store <= fbdr_pkg::CLEAR_VAL; // [R3]
			state_q.outWord.trueOut <= fbdr_pkg::CLEAR_VAL; // [R3]
			state_q.outWord.compOut <= ~fbdr_pkg::CLEAR_VAL; // [R3]
		end else begin
			state_q <= state_d;
		end
	end

	// Pins see flop outputs only
	assign dataOut = state_q.outWord; // [R1]

	// Multi-step checks are built from these; each needs clear low at its end,
	// because a clear arriving between two samples legally zeroes the store
	sequence s_riseNoClear;
		clkRise && !async_clear ##1 !async_clear;
	endsequence

	sequence s_quietNoClear;
		!clkRise && !async_clear ##1 !async_clear;
	endsequence

	sequence s_openClkNoClear;
		clkPair.isOpen && !async_clear ##1 !async_clear;
	endsequence

	sequence s_openDataRise;
		clkRise && !async_clear && dataPair[0].isOpen ##1 !async_clear;
	endsequence

	sequence s_twoFree;
		!async_clear ##1 !async_clear;
	endsequence

	// Clear release with the clock held high, with no rise, or with the clock low and a fresh rise
	sequence s_clearHighClk;
		async_clear && clkLevel;
	endsequence

	sequence s_releaseHeld;
		!async_clear && clkLevel;
	endsequence

	sequence s_clearThenQuiet;
		async_clear ##1 !async_clear && !clkRise;
	endsequence

	sequence s_freshRise;
		async_clear ##1 !async_clear && !clkLevel ##1 clkRise && !async_clear ##1 !async_clear;
	endsequence

	// Clear
	AST_CLEAR_ZERO: assert property ( // [R3]
		@(posedge core_clk) disable iff (!arst_n)
		async_clear |=> state_q.store == fbdr_pkg::CLEAR_VAL)
		else $error("Store not cleared");

	AST_CLEAR_NOW: assert property ( // [R3]
		@(posedge core_clk) disable iff (!arst_n)
		async_clear |-> dataOut.trueOut == fbdr_pkg::CLEAR_VAL)
		else $error("True outputs not low during clear");

	AST_CLEAR_COMP: assert property ( // [R3]
		@(posedge core_clk) disable iff (!arst_n)
		async_clear |-> dataOut.compOut == ~fbdr_pkg::CLEAR_VAL)
		else $error("Complement outputs not high during clear");

	AST_CLEAR_LINK: assert property ( // [R7]
		@(posedge core_clk) disable iff (!arst_n)
		async_clear |=> state_q.linkClk == fbdr_pkg::CLK_HIST_INIT)
		else $error("Clock history not blanked by clear");

	AST_CLEAR_HOLD: assert property ( // [R7]
		@(posedge core_clk) disable iff (!arst_n)
		s_clearThenQuiet |=> state_q.store == fbdr_pkg::CLEAR_VAL)
		else $error("Store left zero without edge");

	AST_NO_RISE_HELD: assert property ( // [R7]
		@(posedge core_clk) disable iff (!arst_n)
		s_clearHighClk ##1 s_releaseHeld |=> state_q.store == fbdr_pkg::CLEAR_VAL)
		else $error("Clock held high through release captured");

	AST_FRESH_RISE: assert property ( // [R7]
		@(posedge core_clk) disable iff (!arst_n)
		s_freshRise |-> state_q.store == $past(dataLevel))
		else $error("Rise after release not captured");

	// Capture and hold
	AST_HOLD: assert property ( // [R2]
		@(posedge core_clk) disable iff (!arst_n)
		s_quietNoClear |-> $stable(state_q.store))
		else $error("Store changed without clock edge");

	AST_HOLD_OUT: assert property ( // [R2]
		@(posedge core_clk) disable iff (!arst_n)
		s_quietNoClear |-> $stable(dataOut))
		else $error("Outputs changed without clock edge");

	AST_CAPTURE: assert property ( // [R2]
		@(posedge core_clk) disable iff (!arst_n)
		s_riseNoClear |-> state_q.store == $past(dataLevel))
		else $error("Data not captured");

	AST_RISE_OUT: assert property ( // [R2]
		@(posedge core_clk) disable iff (!arst_n)
		s_riseNoClear |-> dataOut.trueOut == $past(dataLevel))
		else $error("Captured data not on outputs");

	AST_NO_DOUBLE: assert property ( // [R2]
		@(posedge core_clk) disable iff (!arst_n)
		clkRise |=> !clkRise)
		else $error("Two rises without a low sample");

	AST_LINK_TRACK: assert property ( // [R2]
		@(posedge core_clk) disable iff (!arst_n)
		s_twoFree |-> state_q.linkClk == $past(clkLevel))
		else $error("Clock history lost a sample");

	AST_COMPL: assert property ( // [R1]
		@(posedge core_clk) disable iff (!arst_n)
		dataOut.compOut == ~dataOut.trueOut)
		else $error("Outputs not complementary");

	// Open pairs
	AST_OPEN_DATA: assert property ( // [R4]
		@(posedge core_clk) disable iff (!arst_n)
		s_openDataRise |-> !state_q.store[0])
		else $error("Open data did not read zero");

	AST_OPEN_CLK_LOW: assert property ( // [R4]
		@(posedge core_clk) disable iff (!arst_n)
		clkPair.isOpen |-> !clkLevel)
		else $error("Open clock pair resolved high");

	AST_OPEN_CLK: assert property ( // [R6]
		@(posedge core_clk) disable iff (!arst_n)
		s_openClkNoClear |-> $stable(state_q.store))
		else $error("Open clock changed store");

	AST_BIT_ISOL: assert property ( // [R5]
		@(posedge core_clk) disable iff (!arst_n)
		s_riseNoClear |-> state_q.store[1] == $past(dataLevel[1]))
		else $error("Neighbour bit disturbed");

	// Each lane checked alone, so a fault confined to one bit shows up
	for (genvar i = 0; i < fbdr_pkg::WIDTH; i++) begin : gBitChk
		AST_OPEN_BIT: assert property ( // [R4]
			@(posedge core_clk) disable iff (!arst_n)
			dataPair[i].isOpen |-> !dataLevel[i])
			else $error("Open data pair resolved high");

		AST_CAPT_BIT: assert property ( // [R2]
			@(posedge core_clk) disable iff (!arst_n)
			s_riseNoClear |-> state_q.store[i] == $past(dataLevel[i]))
			else $error("Bit not captured");

		AST_HOLD_BIT: assert property ( // [R2]
			@(posedge core_clk) disable iff (!arst_n)
			s_quietNoClear |-> $stable(state_q.store[i]))
			else $error("Bit changed without clock edge");
	end

endmodule // fbdr_register

// [tb/fbdr_source.sv]
module fbdr_source (
	// Levels and open flags
	input wire logic clkLvl,
	input wire logic clkOff,
	input wire logic [fbdr_pkg::WIDTH-1:0] dat,
	input wire logic [fbdr_pkg::WIDTH-1:0] off,
	// Pairs
	output fbdr_pkg::fbdr_diff_t clkPair,
	output fbdr_pkg::fbdr_diff_t [fbdr_pkg::WIDTH-1:0] dataPair
);
	timeunit 1ns;
	timeprecision 1ns;
	// Open pair shows complement asserted, like the clamp
	assign clkPair = clkOff ? 3'h3 : {clkLvl, ~clkLvl, 1'h0};
	for (genvar i = 0; i < fbdr_pkg::WIDTH; i++) begin : g
		assign dataPair[i] = off[i] ? 3'h3 : {dat[i], ~dat[i], 1'h0};
	end
endmodule // fbdr_source

// [tb/tb_fbdr_register.sv]
module tb_fbdr_register;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 0, arst_n = 0, async_clear = 0, clkLvl = 0, clkOff = 0, prevClk = 0;
	logic [4:0] dat = 5'h00, off = 5'h00, want = 5'h00;
	fbdr_pkg::fbdr_diff_t clkPair;
	fbdr_pkg::fbdr_diff_t [4:0] dataPair;
	fbdr_pkg::fbdr_out_t dataOut;
	fbdr_pkg::fbdr_out_t notes[$];
	int err_count = 0, comparisons = 0, cyc = 0;
	initial forever #5 core_clk = ~core_clk;
	fbdr_source i_fbdr_source(.clkLvl, .clkOff, .dat, .off, .clkPair, .dataPair);
	fbdr_register i_fbdr_register(.core_clk, .arst_n, .async_clear, .clkPair, .dataPair,
		.dataOut);
	task automatic conclude();
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic cmp(fbdr_pkg::fbdr_out_t e);
		comparisons++;
		if (dataOut !== e) begin
			err_count++;
			$display("wrong value at %0t: got %h want %h", $time, dataOut, e);
		end
	endtask
	// Drive at falling edge, note the store after the next rise
	task automatic step(logic c, logic co, logic clr, logic [4:0] d, logic [4:0] o);
		@(negedge core_clk);
		{clkLvl, clkOff, async_clear, dat, off} = {c, co, clr, d, o};
		if (clr) want = 5'h00;
		else if (c & ~co & ~prevClk) want = d & ~o;
		prevClk = c & ~co;
		notes.push_back({want, ~want});
	endtask
	always @(posedge core_clk) begin
		#1;
		if (notes.size() > 0) cmp(notes.pop_front());
		if (++cyc > 500) begin
			err_count++;
			conclude();
		end
	end
	initial begin
		logic c, co, clr = 0;
		void'($urandom(32'h7bb3));
		repeat (4) @(negedge core_clk);
		arst_n = 1;
		notes.push_back({want, ~want});
		for (int i = 0; i < 200; i++) begin
			// No clock rise as clear drops: that edge is ambiguous
			c = clr ? prevClk : 1'($urandom);
			co = ($urandom % 6) == 0;
			clr = ($urandom % 8) == 0;
			step(c, co, clr, 5'($urandom), co ? 5'h00 : 5'($urandom));
		end
		repeat (2) @(negedge core_clk);
		$display("random test done");
		conclude();
	end
endmodule // tb_fbdr_register
